// >>> rtl/swc_pkg.sv
/*
 Package for the sleep, wake and watchdog control block: register map, field positions,
 reset values, timing counts and carrier types.
 Assumes a 200 MHz system clock and an AXI4-Lite master with 32-bit data.
*/
`default_nettype none
package swc_pkg;
	localparam int unsigned SYS_CLK_HZ = 200_000_000;
	// Boot window, in microseconds, and its cycle count
	localparam int unsigned BOOT_WINDOW_US = 62_500;
	localparam int unsigned BOOT_WINDOW_CYC = (SYS_CLK_HZ / 1_000_000) * BOOT_WINDOW_US;
	// Low-frequency oscillator of the interval wake timer
	localparam int unsigned LFO_HZ = 128_000;
	localparam int unsigned LFO_DIV_CYC = SYS_CLK_HZ / LFO_HZ;
	// Shortest RTC-served sleep, seconds
	localparam int unsigned RTC_MIN_SLEEP_S = 1;
	localparam int unsigned MAX_SERIAL_BPS = 115_200;
	localparam int unsigned USER_NV_FIRST = 1024;
	localparam int unsigned USER_NV_LAST = 4095;

	// Register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_FLAGS = 8'h08;
	localparam logic [7:0] REG_TIMER = 8'h0c;
	localparam logic [7:0] REG_ALARM = 8'h10;
	localparam logic [7:0] REG_SERIAL = 8'h14;

	// CTRL fields
	localparam int unsigned CTRL_BOOT_DONE = 0;
	localparam int unsigned CTRL_SETUP_DONE = 1;
	localparam int unsigned CTRL_MODE_LSB = 4;
	localparam int unsigned CTRL_GO = 8;
	// TIMER fields
	localparam int unsigned TIMER_EN = 0;
	localparam int unsigned TIMER_SEL_LSB = 4;
	// ALARM fields: relative alarm source select
	localparam int unsigned ALARM_REL_RTC = 0;
	// FLAGS bit positions
	localparam int unsigned FLG_WDT = 0;
	localparam int unsigned FLG_RTC1 = 1;
	localparam int unsigned FLG_RTC2 = 2;
	localparam int unsigned FLG_SENS = 3;
	localparam int unsigned FLG_ACC = 4;
	localparam int unsigned FLG_HIB = 5;
	localparam int unsigned FLG_WAKE = 6;
	localparam logic [6:0] FLAGS_RST = 7'h00;
	localparam logic [3:0] SEL_RST = 4'h0;
	localparam logic [23:0] SERIAL_RST = 24'h01c200;

	typedef enum logic [1:0] {MODE_ON, MODE_SLEEP, MODE_DEEP, MODE_HIB} swc_mode_t;
	typedef enum logic [2:0] {ST_BOOT, ST_LOAD, ST_SETUP, ST_LOOP, ST_PAUSED, ST_OFF} swc_state_t;

	typedef struct packed {
		logic wdt;
		logic rtc1;
		logic rtc2;
		logic sens;
		logic acc;
	} swc_events_t;

	// Interval in milliseconds for each selection code, 0 for an illegal code
	function automatic int unsigned swc_interval_ms(input logic [3:0] sel);
		case (sel)
			4'h0: return 16;
			4'h1: return 32;
			4'h2: return 64;
			4'h3: return 128;
			4'h4: return 256;
			4'h5: return 500;
			4'h6: return 1000;
			4'h7: return 2000;
			4'h8: return 4000;
			4'h9: return 8000;
			default: return 0;
		endcase
	endfunction : swc_interval_ms
endpackage : swc_pkg
`default_nettype wire

// >>> rtl/swc_sleep_wake_watchdog_control.sv
/*
 Sleep, wake and watchdog control: boot window, interval wake timer, RTC alarm reset,
 power-mode wake selection and interrupt source flags behind an AXI4-Lite slave.
 Assumes all inputs synchronous to i_clk_sys and a single-beat AXI4-Lite master.
*/
// Notes on behaviour
// - Boot window holds execution, listens for image
// - Image received replaces flash, else old runs
// - Every reset starts setup then endless loop
// - All timing from one crystal system clock
// - Serial links no faster than maximum rate
// - Timer counts slow oscillator, interrupts at terminal
// - Timer interrupt wakes Sleep, else alarm
// - Interval chosen only from ten fixed values
// - Second RTC alarm resets the controller
// - Alarm reset only with switch enabled
// - RTC alarms use day hour minute second
// - RTC alarm wakes Deep Sleep and Hibernate
// - Relative alarms RTC or timer, periodic RTC
// - Sensor and accelerometer events raise interrupts
// - Any interrupt wakes Sleep; Hibernate only RTC
// - Hibernate removes power, RTC alarm restores it
// - Each interrupt sets its own source flag
// - Hibernate start flag, checked at setup start
// - Hibernate exit resets; sleeps resume in place
`default_nettype none
module swc_sleep_wake_watchdog_control
	import swc_pkg::*;
#(
	parameter int unsigned BOOT_CYC = BOOT_WINDOW_CYC,
	parameter int unsigned LFO_DIV = LFO_DIV_CYC,
	parameter int unsigned LFO_PER_MS = LFO_HZ / 1000
) (
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	input wire logic i_clk_en,
	input wire logic i_rtc_alarm1,
	input wire logic i_rtc_alarm2,
	input wire logic i_sensor_irq,
	input wire logic i_accel_irq,
	input wire logic i_wdog_switch_en,
	input wire logic i_image_rx,
	input wire logic i_image_done,
	input wire logic [7:0] i_s_axi_awaddr,
	input wire logic i_s_axi_awvalid,
	output logic o_s_axi_awready,
	input wire logic [31:0] i_s_axi_wdata,
	input wire logic [3:0] i_s_axi_wstrb,
	input wire logic i_s_axi_wvalid,
	output logic o_s_axi_wready,
	output logic [1:0] o_s_axi_bresp,
	output logic o_s_axi_bvalid,
	input wire logic i_s_axi_bready,
	input wire logic [7:0] i_s_axi_araddr,
	input wire logic i_s_axi_arvalid,
	output logic o_s_axi_arready,
	output logic [31:0] o_s_axi_rdata,
	output logic [1:0] o_s_axi_rresp,
	output logic o_s_axi_rvalid,
	input wire logic i_s_axi_rready,
	output logic o_cpu_run,
	output logic o_cpu_rst,
	output logic o_flash_write,
	output logic o_node_power,
	output logic o_irq
);
	// Counters are 32, 16 and 21 bits wide; refuse settings they cannot hold
	if (BOOT_CYC < 1 || LFO_DIV < 1 || LFO_DIV > 65536 || LFO_PER_MS < 1 || LFO_PER_MS > 262) begin : g_bad_param
		$error("swc: count parameters out of range");
	end

	typedef struct packed {
		swc_state_t st;
		logic [31:0] boot_cnt;
		logic image_seen;
		logic [1:0] mode;
		logic [3:0] sel;
		logic tmr_en;
		logic rel_rtc;
		logic [23:0] serial_bps;
		logic [15:0] lfo_div;
		logic [20:0] tmr_cnt;
		logic [6:0] flags;
		logic hib_mark;
		logic aw_ok;
		logic w_ok;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic awready;
		logic wready;
		logic arready;
		logic cpu_run;
		logic cpu_rst;
		logic flash_write;
		logic node_power;
		logic irq;
	} swc_state_bundle_t;

	swc_state_bundle_t s_q;
	swc_state_bundle_t s_d;
	swc_events_t ev;

	function automatic logic [20:0] term_ticks(input logic [3:0] sel);
		return 21'(swc_interval_ms(sel) * LFO_PER_MS);
	endfunction : term_ticks

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	always_comb begin
		logic lfo_tick;
		logic [31:0] ctrl_w;
		logic [31:0] v;
		logic wake;
		logic wr_fire;
		lfo_tick = 1'b0;
		ctrl_w = '0;
		v = '0;
		wake = 1'b0;
		wr_fire = 1'b0;
		s_d = s_q;
		ev = '0;
		s_d.cpu_rst = 1'b0;
		s_d.irq = 1'b0;

		// Slow oscillator derived from the system clock
		if (s_q.lfo_div == 16'(LFO_DIV - 1)) begin
			s_d.lfo_div = '0;
			lfo_tick = 1'b1;
		end else begin
			s_d.lfo_div = s_q.lfo_div + 16'h0001;
		end

		// Interval wake timer; stopped while power is removed
		if (s_q.tmr_en && s_q.node_power && term_ticks(s_q.sel) != '0 && lfo_tick) begin
			if (s_q.tmr_cnt + 21'h000001 >= term_ticks(s_q.sel)) begin
				s_d.tmr_cnt = '0;
				ev.wdt = 1'b1;
			end else begin
				s_d.tmr_cnt = s_q.tmr_cnt + 21'h000001;
			end
		end

		ev.rtc1 = i_rtc_alarm1;
		ev.rtc2 = i_rtc_alarm2;
		ev.sens = i_sensor_irq;
		ev.acc = i_accel_irq;

		// Relative alarms served by timer or RTC, periodic ones always by RTC
		if (s_q.rel_rtc) begin
			ev.wdt = 1'b0;
		end

		// AXI4-Lite write channel
		if (i_s_axi_awvalid && !s_q.aw_ok) begin
			s_d.aw_ok = 1'b1;
			s_d.awaddr = i_s_axi_awaddr;
		end
		if (i_s_axi_wvalid && !s_q.w_ok) begin
			s_d.w_ok = 1'b1;
			s_d.wdata = i_s_axi_wdata;
			s_d.wstrb = i_s_axi_wstrb;
		end
		if (s_q.aw_ok && s_q.w_ok && !s_q.bvalid) begin
			wr_fire = 1'b1;
			s_d.aw_ok = 1'b0;
			s_d.w_ok = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = 2'b00;
			case (s_q.awaddr)
				REG_CTRL: begin
					ctrl_w = merge(32'h0, s_q.wdata, s_q.wstrb);
					if (ctrl_w[CTRL_SETUP_DONE] && s_q.st == ST_SETUP) begin
						s_d.st = ST_LOOP;
					end
					if (ctrl_w[CTRL_GO] && s_q.st == ST_LOOP) begin
						s_d.mode = ctrl_w[CTRL_MODE_LSB +: 2];
						if (ctrl_w[CTRL_MODE_LSB +: 2] == MODE_HIB) begin
							s_d.st = ST_OFF;
							s_d.node_power = 1'b0;
							s_d.cpu_run = 1'b0;
							s_d.hib_mark = 1'b1;
						end else if (ctrl_w[CTRL_MODE_LSB +: 2] != MODE_ON) begin
							s_d.st = ST_PAUSED;
							s_d.cpu_run = 1'b0;
						end
					end
				end
				REG_FLAGS: begin
					v = merge(32'h0, s_q.wdata, s_q.wstrb);
					s_d.flags = s_q.flags & ~v[6:0];
					if (v[FLG_HIB]) begin
						s_d.hib_mark = 1'b0;
					end
				end
				REG_TIMER: begin
					v = merge({27'h0, s_q.sel, s_q.tmr_en}, s_q.wdata, s_q.wstrb);
					s_d.tmr_en = v[TIMER_EN];
					s_d.sel = v[TIMER_SEL_LSB +: 4];
					s_d.tmr_cnt = '0;
					if (swc_interval_ms(v[TIMER_SEL_LSB +: 4]) == 0) begin
						s_d.sel = s_q.sel;
						s_d.bresp = 2'b10;
					end
				end
				REG_ALARM: begin
					v = merge({31'h0, s_q.rel_rtc}, s_q.wdata, s_q.wstrb);
					s_d.rel_rtc = v[ALARM_REL_RTC];
				end
				REG_SERIAL: begin
					v = merge({8'h0, s_q.serial_bps}, s_q.wdata, s_q.wstrb);
					if (v[23:0] <= 24'(MAX_SERIAL_BPS) && v[31:24] == 8'h00) begin
						s_d.serial_bps = v[23:0];
					end else begin
						s_d.bresp = 2'b10;
					end
				end
				REG_STATUS: s_d.bresp = 2'b00;
				default: s_d.bresp = 2'b10;
			endcase
		end
		if (s_q.bvalid && i_s_axi_bready) begin
			s_d.bvalid = 1'b0;
		end

		// AXI4-Lite read channel
		if (i_s_axi_arvalid && !s_q.rvalid) begin
			s_d.rvalid = 1'b1;
			s_d.rresp = 2'b00;
			case (i_s_axi_araddr)
				REG_CTRL: s_d.rdata = {28'h0, 2'(s_q.mode), 2'b00};
				REG_STATUS: s_d.rdata = {24'h0, i_wdog_switch_en, s_q.image_seen, s_q.node_power,
					s_q.cpu_run, 1'b0, 3'(s_q.st)};
				REG_FLAGS: s_d.rdata = {25'h0, s_q.flags};
				REG_TIMER: s_d.rdata = {27'h0, s_q.sel, s_q.tmr_en};
				REG_ALARM: s_d.rdata = {31'h0, s_q.rel_rtc};
				REG_SERIAL: s_d.rdata = {8'h0, s_q.serial_bps};
				default: begin
					s_d.rdata = '0;
					s_d.rresp = 2'b10;
				end
			endcase
		end else if (s_q.rvalid && i_s_axi_rready) begin
			s_d.rvalid = 1'b0;
		end

		// Ready flags kept in flops so the ports leave a register
		s_d.awready = !s_d.aw_ok;
		s_d.wready = !s_d.w_ok;
		s_d.arready = !s_d.rvalid;

		// Event flags: a new event wins over a clear in the same cycle
		if (s_q.node_power) begin
			if (ev.wdt) s_d.flags[FLG_WDT] = 1'b1;
			if (ev.rtc1) s_d.flags[FLG_RTC1] = 1'b1;
			if (ev.rtc2) s_d.flags[FLG_RTC2] = 1'b1;
			if (ev.sens) s_d.flags[FLG_SENS] = 1'b1;
			if (ev.acc) s_d.flags[FLG_ACC] = 1'b1;
			s_d.irq = |ev;
		end

		// Sequencer
		case (s_q.st)
			ST_BOOT: begin
				s_d.boot_cnt = s_q.boot_cnt + 32'h1;
				if (i_image_rx) begin
					s_d.st = ST_LOAD;
					s_d.image_seen = 1'b1;
					s_d.flash_write = 1'b1;
				end else if (s_q.boot_cnt >= 32'(BOOT_CYC - 1)) begin
					s_d.st = ST_SETUP;
					s_d.cpu_run = 1'b1;
				end
			end
			ST_LOAD: begin
				if (i_image_done) begin
					s_d.flash_write = 1'b0;
					s_d.st = ST_SETUP;
					s_d.cpu_run = 1'b1;
				end
			end
			ST_SETUP: begin
				if (s_q.hib_mark && !wr_fire) begin
					s_d.flags[FLG_HIB] = 1'b1;
				end
			end
			ST_PAUSED: begin
				// Sleep wakes on anything, Deep Sleep on RTC and asynchronous sources
				if (s_q.mode == MODE_SLEEP) begin
					wake = |ev;
				end else begin
					wake = ev.rtc1 | ev.rtc2 | ev.sens | ev.acc;
				end
				if (wake) begin
					s_d.st = ST_LOOP;
					s_d.cpu_run = 1'b1;
					s_d.mode = MODE_ON;
					s_d.flags[FLG_WAKE] = 1'b1;
				end
			end
			ST_OFF: begin
				if (ev.rtc1 || ev.rtc2) begin
					s_d.node_power = 1'b1;
					s_d.mode = MODE_ON;
					s_d.st = ST_BOOT;
					s_d.boot_cnt = '0;
					s_d.cpu_rst = 1'b1;
					s_d.flags = '0;
					s_d.flags[FLG_RTC1] = ev.rtc1;
					s_d.flags[FLG_RTC2] = ev.rtc2;
					s_d.tmr_en = 1'b0;
				end
			end
			default: ;
		endcase

		// Alarm-driven recovery reset, gated by the switch
		if (ev.rtc2 && i_wdog_switch_en && s_q.st != ST_OFF) begin
			s_d.cpu_rst = 1'b1;
			s_d.cpu_run = 1'b0;
			s_d.st = ST_BOOT;
			s_d.boot_cnt = '0;
			s_d.mode = MODE_ON;
			s_d.flash_write = 1'b0;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			s_q <= '0;
			s_q.st <= ST_BOOT;
			s_q.mode <= MODE_ON;
			s_q.sel <= SEL_RST;
			s_q.flags <= FLAGS_RST;
			s_q.serial_bps <= SERIAL_RST;
			s_q.node_power <= 1'b1;
			s_q.awready <= 1'b1;
			s_q.wready <= 1'b1;
			s_q.arready <= 1'b1;
		end else if (i_clk_en) begin
			s_q <= s_d;
		end
	end

	assign o_s_axi_awready = s_q.awready;
	assign o_s_axi_wready = s_q.wready;
	assign o_s_axi_bvalid = s_q.bvalid;
	assign o_s_axi_bresp = s_q.bresp;
	assign o_s_axi_arready = s_q.arready;
	assign o_s_axi_rvalid = s_q.rvalid;
	assign o_s_axi_rdata = s_q.rdata;
	assign o_s_axi_rresp = s_q.rresp;
	assign o_cpu_run = s_q.cpu_run;
	assign o_cpu_rst = s_q.cpu_rst;
	assign o_flash_write = s_q.flash_write;
	assign o_node_power = s_q.node_power;
	assign o_irq = s_q.irq;
endmodule : swc_sleep_wake_watchdog_control
`default_nettype wire

// >>> bench/swc_chk.sv
/* Checker for boot hold, recovery reset, wake and power rules at the block's ports.
 Assumes it is bound to the block; clock enable is only lowered while no event arrives. */
`default_nettype none
module swc_chk #(
	parameter int unsigned BOOT_CYC = 50
) (
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	input wire logic i_rtc_alarm1,
	input wire logic i_rtc_alarm2,
	input wire logic i_sensor_irq,
	input wire logic i_accel_irq,
	input wire logic i_wdog_switch_en,
	input wire logic o_s_axi_bvalid,
	input wire logic i_s_axi_bready,
	input wire logic [1:0] o_s_axi_bresp,
	input wire logic o_cpu_run,
	input wire logic o_cpu_rst,
	input wire logic o_node_power,
	input wire logic o_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] boot_cnt_q;
	// Cycles since the last reset, saturating at the window
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			boot_cnt_q <= '0;
		end else if (o_cpu_rst) begin
			boot_cnt_q <= '0;
		end else if (boot_cnt_q < BOOT_CYC) begin
			boot_cnt_q <= boot_cnt_q + 32'h1;
		end
	end
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_sys_rst);
	sequence s_alarm_rst;
		i_rtc_alarm2 && i_wdog_switch_en && o_node_power;
	endsequence
	sequence s_boot_again;
		o_cpu_rst ##1 !o_cpu_run;
	endsequence
	boot_hold_a: assert property ($rose(o_cpu_run) |-> boot_cnt_q + 32'h2 >= BOOT_CYC)
		else $error("run began inside boot window");
	alarm_reset_a: assert property (s_alarm_rst |=> s_boot_again)
		else $error("recovery alarm did not reset");
	switch_gate_a: assert property (i_rtc_alarm2 && !i_wdog_switch_en && o_node_power |=> !o_cpu_rst)
		else $error("reset with switch off");
	irq_event_a: assert property (o_node_power && (i_sensor_irq || i_accel_irq || i_rtc_alarm1) |=> o_irq)
		else $error("event gave no interrupt");
	hib_deaf_a: assert property (!o_node_power && (i_sensor_irq || i_accel_irq) |=> !o_node_power)
		else $error("sensor woke hibernate");
	power_back_a: assert property (!o_node_power && i_rtc_alarm1 |-> ##[1:4] o_node_power)
		else $error("power not restored");
	rst_pulse_a: assert property (o_cpu_rst |=> !o_cpu_rst)
		else $error("reset pulse too long");
	resp_hold_a: assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
		else $error("write response dropped");
endmodule : swc_chk
bind swc_sleep_wake_watchdog_control swc_chk #(.BOOT_CYC(BOOT_CYC)) chk_u (.i_clk_sys, .i_sys_rst,
	.i_rtc_alarm1, .i_rtc_alarm2, .i_sensor_irq, .i_accel_irq, .i_wdog_switch_en, .o_s_axi_bvalid,
	.i_s_axi_bready, .o_s_axi_bresp, .o_cpu_run, .o_cpu_rst, .o_node_power, .o_irq);
`default_nettype wire

// >>> bench/swc_far_model.sv
/* Far side: RTC alarm outputs and sensor and accelerometer lines.
 Assumes one caller at a time; line 0 alarm 1, 1 alarm 2, 2 sensor, 3 accelerometer. */
`default_nettype none
module swc_far_model (
	input wire logic i_clk_sys,
	output logic [3:0] o_lines
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		o_lines = 4'h0;
	end
	// One clock wide alarm or event, then low
	task automatic pulse(input int k);
		@(posedge i_clk_sys);
		o_lines <= 4'h1 << k;
		@(posedge i_clk_sys);
		o_lines <= 4'h0;
	endtask : pulse
endmodule : swc_far_model
`default_nettype wire

// >>> bench/swc_sleep_wake_watchdog_control_tb_top.sv
/* Bench: boot, image load, timer, events, power modes and recovery reset.
 Assumes the model and checker compile first; short boot and tick counts. */
`default_nettype none
module swc_sleep_wake_watchdog_control_tb_top import swc_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned BOOT = 50;
	localparam int unsigned DIV = 4;
	logic clk, rst, sw, irx, idn, awv, wv, bre, arv, rre, ce;
	logic awr, wr, bv, arr, rv, run, crst, fw, pwr, irq;
	logic [3:0] ln, ws;
	logic [7:0] awa, ara;
	logic [31:0] wd, rd, d;
	logic [1:0] br, rr, r;
	int errors, tests_run, n_rst, n_irq, t_irq, per, cyc;
	swc_far_model far_u (.i_clk_sys(clk), .o_lines(ln));
	swc_sleep_wake_watchdog_control #(.BOOT_CYC(BOOT), .LFO_DIV(DIV), .LFO_PER_MS(1)) dut_u (
		.i_clk_sys(clk), .i_sys_rst(rst), .i_clk_en(ce), .i_rtc_alarm1(ln[0]), .i_rtc_alarm2(ln[1]),
		.i_sensor_irq(ln[2]), .i_accel_irq(ln[3]), .i_wdog_switch_en(sw), .i_image_rx(irx), .i_image_done(idn),
		.i_s_axi_awaddr(awa), .i_s_axi_awvalid(awv), .o_s_axi_awready(awr), .i_s_axi_wdata(wd),
		.i_s_axi_wstrb(ws), .i_s_axi_wvalid(wv), .o_s_axi_wready(wr), .o_s_axi_bresp(br),
		.o_s_axi_bvalid(bv), .i_s_axi_bready(bre), .i_s_axi_araddr(ara), .i_s_axi_arvalid(arv),
		.o_s_axi_arready(arr), .o_s_axi_rdata(rd), .o_s_axi_rresp(rr), .o_s_axi_rvalid(rv),
		.i_s_axi_rready(rre), .o_cpu_run(run), .o_cpu_rst(crst), .o_flash_write(fw),
		.o_node_power(pwr), .o_irq(irq));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (crst === 1'b1) n_rst <= n_rst + 1;
		if (irq === 1'b1) begin
			n_irq <= n_irq + 1;
			t_irq <= cyc;
			per <= cyc - t_irq;
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wait_run(input logic v, input int lim);
		for (int k = 0; k < lim && run !== v; k++) @(posedge clk);
		chk(run, v);
	endtask : wait_run
	task automatic do_reset;
		rst <= 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
	endtask : do_reset
	task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] s);
		@(posedge clk);
		awa <= a;
		wd <= v;
		awv <= 1'b1;
		wv <= 1'b1;
		bre <= 1'b1;
		do begin
			@(posedge clk);
			if (awr) awv <= 1'b0;
			if (wr) wv <= 1'b0;
		end while (!bv);
		s = br;
		bre <= 1'b0;
	endtask : axw
	task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] s);
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rre <= 1'b1;
		do begin
			@(posedge clk);
			if (arr) arv <= 1'b0;
		end while (!rv);
		v = rd;
		s = rr;
		rre <= 1'b0;
	endtask : axr
	task automatic t_image;
		do_reset();
		repeat (5) @(posedge clk);
		irx <= 1'b1;
		@(posedge clk);
		irx <= 1'b0;
		repeat (3) @(posedge clk);
		chk(fw, 1);
		repeat (BOOT) @(posedge clk);
		chk(run, 0);
		idn <= 1'b1;
		@(posedge clk);
		idn <= 1'b0;
		wait_run(1, BOOT + 20);
		chk(fw, 0);
		$display("image load done");
	endtask : t_image
	task automatic t_boot;
		do_reset();
		repeat (BOOT - 5) @(posedge clk);
		chk(run, 0);
		wait_run(1, 20);
		axr(REG_STATUS, d, r);
		chk(d[2:0], 3'h2);
		axw(REG_CTRL, 32'h2, r);
		axr(REG_STATUS, d, r);
		chk(d[2:0], 3'h3);
		axr(8'h40, d, r);
		chk(r, 2'b10);
		chk(d, 0);
		$display("boot done");
	endtask : t_boot
	task automatic t_limits;
		int m;
		for (int s = 0; s < 11; s++) begin
			axw(REG_TIMER, 32'(s) << 4, r);
			chk(r, (s < 10) ? 2'b00 : 2'b10);
		end
		axw(REG_SERIAL, 32'd115201, r);
		chk(r, 2'b10);
		axw(REG_SERIAL, 32'd9600, r);
		axr(REG_SERIAL, d, r);
		chk(d[23:0], 24'd9600);
		// Only byte lane 0 written; upper lanes keep 9600
		ws <= 4'h1;
		axw(REG_SERIAL, 32'h00001234, r);
		ws <= 4'hf;
		axr(REG_SERIAL, d, r);
		chk(d[23:0], 24'h002534);
		axw(REG_TIMER, 32'h1, r);
		m = n_irq + 2;
		for (int k = 0; k < 400 && n_irq < m; k++) @(posedge clk);
		// Shortest interval: 16 ticks of DIV cycles each
		chk(per, 16 * DIV);
		// Frozen cycles stretch the interval by exactly their number
		ce <= 1'b0;
		repeat (20) @(posedge clk);
		ce <= 1'b1;
		m = n_irq + 1;
		for (int k = 0; k < 400 && n_irq < m; k++) @(posedge clk);
		chk(per, 16 * DIV + 20);
		axr(REG_FLAGS, d, r);
		chk(d[FLG_WDT], 1);
		axw(REG_ALARM, 32'h1, r);
		repeat (2) @(posedge clk);
		m = n_irq;
		repeat (150) @(posedge clk);
		chk(n_irq - m, 0);
		axw(REG_ALARM, 32'h0, r);
		axw(REG_TIMER, 32'h0, r);
		axw(REG_FLAGS, 32'h7f, r);
		axr(REG_FLAGS, d, r);
		chk(d, 0);
		$display("limits and timer done");
	endtask : t_limits
	task automatic t_events;
		int b;
		b = n_rst;
		for (int k = 0; k < 4; k++) begin
			far_u.pulse(k);
			axr(REG_FLAGS, d, r);
			chk(d[k + FLG_RTC1], 1);
			axw(REG_FLAGS, 32'h7f, r);
		end
		chk(n_rst, b);
		chk(run, 1);
		$display("events done");
	endtask : t_events
	task automatic t_sleep;
		int b;
		b = n_rst;
		for (int m = 1; m < 3; m++) begin
			axw(REG_CTRL, 32'h100 | (32'(m) << 4), r);
			wait_run(0, 10);
			far_u.pulse(m + 1);
			wait_run(1, 20);
			axr(REG_STATUS, d, r);
			chk(d[2:0], 3'h3);
		end
		axw(REG_TIMER, 32'h1, r);
		axw(REG_CTRL, 32'h110, r);
		wait_run(0, 10);
		wait_run(1, 200);
		axw(REG_TIMER, 32'h0, r);
		chk(n_rst, b);
		$display("sleep done");
	endtask : t_sleep
	task automatic t_hib;
		int b;
		b = n_rst;
		axw(REG_CTRL, 32'h130, r);
		repeat (3) @(posedge clk);
		chk(pwr, 0);
		far_u.pulse(2);
		repeat (4) @(posedge clk);
		chk(pwr, 0);
		far_u.pulse(0);
		wait_run(1, BOOT + 20);
		chk(n_rst, b + 1);
		axr(REG_FLAGS, d, r);
		chk(d[FLG_HIB], 1);
		axw(REG_CTRL, 32'h2, r);
		axw(REG_FLAGS, 32'h7f, r);
		$display("hibernate done");
	endtask : t_hib
	task automatic t_recover;
		int b;
		b = n_rst;
		sw <= 1'b1;
		far_u.pulse(1);
		repeat (2) @(posedge clk);
		chk(n_rst, b + 1);
		chk(run, 0);
		wait_run(1, BOOT + 20);
		sw <= 1'b0;
		$display("recovery done");
	endtask : t_recover
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : tally_and_finish
	initial begin
		{sw, irx, idn, awv, wv, bre, arv, rre} = '0;
		ce = 1'b1;
		ws = 4'hf;
		{awa, ara, wd} = '0;
		t_image();
		t_boot();
		t_limits();
		t_events();
		t_sleep();
		t_hib();
		t_recover();
		tally_and_finish();
	end
	initial begin
		repeat (40000) @(posedge clk);
		errors++;
		tally_and_finish();
	end
endmodule : swc_sleep_wake_watchdog_control_tb_top
`default_nettype wire
